// file: hdl/slld_cfg.svh
/*
  Constants of the serial load and LO direction block: APB offsets, field
  positions, reset values and widths.
  Assumes it is included by the package, the design modules and the testbench.
*/
// What this block does
// - With the port enabled, each rising serial clock edge shifts the data bit into the 24-bit register.
// - With the port enabled, commit strobe rising copies the shift word into the register its 3 select bits name.
// - LO pins are inputs when pin low, drive bit 0, external bit 1; divider 0.
// - LO pins are outputs when pin high, or drive 1 and external 0; divider 1.
`ifndef SLLD_CFG_SVH
`define SLLD_CFG_SVH

// =====================================================================
// Word layout
`define SLLD_WORD_W        24
`define SLLD_SEL_W         3
`define SLLD_NREG          8
`define SLLD_LO_REG        3'h5
`define SLLD_LO_DRV_BIT    3
`define SLLD_LO_EXT_BIT    4
`define SLLD_LO_DIV_BIT    5

// =====================================================================
// APB map, byte addresses
`define SLLD_ADDR_W        12
`define SLLD_OFF_CTRL      12'h000
`define SLLD_OFF_STATUS    12'h004
`define SLLD_OFF_SHIFT     12'h008
`define SLLD_OFF_WORD0     12'h020
`define SLLD_OFF_WORD_END  12'h03c

// =====================================================================
// Register fields and reset values
`define SLLD_CTRL_EN_BIT   0
`define SLLD_CTRL_RST      32'h0000_0001
`define SLLD_ST_OUT_BIT    0
`define SLLD_ST_IN_BIT     1
`define SLLD_ST_PIN_BIT    2
`define SLLD_ST_DIVBAD_BIT 3
`define SLLD_ST_CNT_LSB    8

`endif

// file: hdl/slld_pkg.sv
/*
  Types of the serial load and LO direction block.
  Assumes slld_cfg.svh is on the include path.
*/
`include "slld_cfg.svh"

package slld_pkg;

  // =====================================================================
  // Shared types
  typedef logic [`SLLD_WORD_W-1:0] slld_word_t;
  typedef logic [`SLLD_SEL_W-1:0]  slld_sel_t;

  // Pin levels, raw or filtered, one bit per serial or direction input.
  typedef struct packed {
    logic dirpin;
    logic strobe;
    logic sdata;
    logic sclk;
  } slld_pins_s;

  // LO path control bits kept from the LO register.
  typedef struct packed {
    logic div;
    logic ext;
    logic drv;
  } slld_lo_s;

endpackage : slld_pkg

// file: hdl/slld_regmem.sv
/*
  Internal register store: eight words written by a committed serial word,
  read by the APB side through a registered read port.
  Assumes one clock, an active-low asynchronous reset and a clock enable.
*/
`timescale 1ns/10ps
`include "slld_cfg.svh"

module slld_regmem
  import slld_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       we,
  input  wire slld_sel_t  waddr,
  input  wire slld_word_t wdata,
  input  wire logic       re,
  input  wire slld_sel_t  raddr,
  output slld_word_t      rdata_r
);

  slld_word_t mem_r [`SLLD_NREG];

  // =====================================================================
  // Storage; reset so every programmed setting starts at a known value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `SLLD_NREG; i++) begin
        mem_r[i] <= '0;
      end
    end else if (clk_en && we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // Read data leaves through a register, so the bus sees a clean level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
    end else if (clk_en && re) begin
      rdata_r <= mem_r[raddr];
    end
  end

endmodule : slld_regmem

// file: hdl/slld_top.sv
/*
  Serial load port and LO direction logic. The serial clock, data, commit
  strobe and LO direction pin come from outside and are sampled on pclk.
  Software reaches control, status and the committed words over APB.
  Assumes pclk is at least eight times the serial clock rate, so each
  serial level lasts several samples after filtering.
*/
`timescale 1ns/10ps
`include "slld_cfg.svh"

module slld_top
  import slld_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SLLD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Serial programming pins.
  input  wire logic                    sclk,
  input  wire logic                    sdata,
  input  wire logic                    word_commit_strobe,
  input  wire logic                    lo_direction_pin,
  // Internal LO source and the two-way LO pin pair.
  input  wire logic                    lo_source,
  input  wire logic                    lo_port_positive_i,
  output logic                         lo_port_positive_o,
  output logic                         lo_port_positive_oe_n,
  input  wire logic                    lo_port_negative_i,
  output logic                         lo_port_negative_o,
  output logic                         lo_port_negative_oe_n,
  output logic                         lo_ext_positive_r,
  output logic                         lo_ext_negative_r,
  output logic                         lo_is_output
);

  // =====================================================================
  // Pin synchronisers and filter
  slld_pins_s raw;
  slld_pins_s filt;
  slld_pins_s filt_d_r;

  assign raw = '{dirpin: lo_direction_pin, strobe: word_commit_strobe, sdata: sdata, sclk: sclk};

  // Three synchroniser flops and a filter flop per pin; a new level counts only once the second and third agree.
  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic f_r;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        f_r  <= 1'b0;
      end else if (clk_en) begin
        s1_r <= raw[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          f_r <= s3_r;
        end
      end
    end
    assign filt[g] = f_r;
  end

  // Previous filtered levels for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_d_r <= '0;
    end else if (clk_en) begin
      filt_d_r <= filt;
    end
  end

  // =====================================================================
  // Control register and edge decode
  logic [31:0] ctrl_r;
  logic        port_en;
  logic        sclk_rise;
  logic        strobe_rise;

  assign port_en     = ctrl_r[`SLLD_CTRL_EN_BIT];
  assign sclk_rise   = port_en & filt.sclk & ~filt_d_r.sclk;
  assign strobe_rise = port_en & filt.strobe & ~filt_d_r.strobe;

  // =====================================================================
  // Shift register and commit
  slld_word_t shift_r;
  slld_word_t shift_nxt;
  slld_sel_t  commit_sel;
  logic [7:0] commit_cnt_r;
  slld_lo_s   lo_r;

  // MSB first: each new bit enters at the bottom, so the last three select.
  assign shift_nxt  = {shift_r[`SLLD_WORD_W-2:0], filt.sdata};
  assign commit_sel = shift_r[`SLLD_SEL_W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= '0;
    end else if (clk_en && sclk_rise) begin
      shift_r <= shift_nxt;
    end
  end

  // Only a commit touches the stored words and the LO bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_r         <= '0;
      commit_cnt_r <= 8'h00;
    end else if (clk_en && strobe_rise) begin
      commit_cnt_r <= commit_cnt_r + 8'h01;
      if (commit_sel == `SLLD_LO_REG) begin
        lo_r.drv <= shift_r[`SLLD_LO_DRV_BIT];
        lo_r.ext <= shift_r[`SLLD_LO_EXT_BIT];
        lo_r.div <= shift_r[`SLLD_LO_DIV_BIT];
      end
    end
  end

  // =====================================================================
  // Committed word store
  logic       apb_setup;
  logic       word_hit;
  slld_sel_t  word_idx;
  slld_word_t mem_rdata;

  assign apb_setup = psel & ~penable;
  assign word_hit  = (paddr >= `SLLD_OFF_WORD0) && (paddr <= `SLLD_OFF_WORD_END) && (paddr[1:0] == 2'b00);
  assign word_idx  = paddr[4:2];

  slld_regmem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .we      (strobe_rise),
    .waddr   (commit_sel),
    .wdata   (shift_r),
    .re      (apb_setup && !pwrite && word_hit),
    .raddr   (word_idx),
    .rdata_r (mem_rdata)
  );

  // =====================================================================
  // LO direction
  logic mode_out;
  logic mode_in;
  logic div_bad;

  // The pin forces outputs; otherwise the two register bits decide.
  assign mode_out = filt.dirpin | (lo_r.drv & ~lo_r.ext);
  assign mode_in  = ~filt.dirpin & ~lo_r.drv & lo_r.ext;
  // The divider bit must follow the direction; flag a mismatch for software.
  assign div_bad  = (mode_out & ~lo_r.div) | (mode_in & lo_r.div);

  // Other register combinations leave the pins undriven, which is the safe choice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_is_output          <= 1'b0;
      lo_port_positive_o    <= 1'b0;
      lo_port_negative_o    <= 1'b0;
      lo_port_positive_oe_n <= 1'b1;
      lo_port_negative_oe_n <= 1'b1;
      lo_ext_positive_r     <= 1'b0;
      lo_ext_negative_r     <= 1'b0;
    end else if (clk_en) begin
      lo_is_output          <= mode_out;
      lo_port_positive_o    <= lo_source;
      lo_port_negative_o    <= ~lo_source;
      lo_port_positive_oe_n <= ~mode_out;
      lo_port_negative_oe_n <= ~mode_out;
      lo_ext_positive_r     <= mode_in & lo_port_positive_i;
      lo_ext_negative_r     <= mode_in & lo_port_negative_i;
    end
  end

  // =====================================================================
  // APB slave
  logic        sel_mem_r;
  logic        err_r;
  logic [31:0] misc_r;
  logic [31:0] status;
  logic        hit_ctrl;
  logic        hit_ro;
  logic        apb_write;

  assign status = {16'h0000, commit_cnt_r, 4'h0, div_bad, filt.dirpin, mode_in, mode_out};
  assign hit_ctrl  = (paddr == `SLLD_OFF_CTRL);
  assign hit_ro    = (paddr == `SLLD_OFF_STATUS) || (paddr == `SLLD_OFF_SHIFT) || word_hit;
  assign apb_write = psel & penable & pwrite & hit_ctrl & ~err_r;

  // Decode and capture in the setup cycle, so the access phase never waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_mem_r <= 1'b0;
      err_r     <= 1'b0;
      misc_r    <= 32'h0000_0000;
    end else if (clk_en && apb_setup) begin
      sel_mem_r <= ~pwrite & word_hit;
      err_r     <= pwrite ? ~hit_ctrl : ~(hit_ctrl | hit_ro);
      misc_r    <= pwrite ? 32'h0000_0000 :
                   hit_ctrl ? ctrl_r :
                   (paddr == `SLLD_OFF_STATUS) ? status :
                   (paddr == `SLLD_OFF_SHIFT) ? {8'h00, shift_r} : 32'h0000_0000;
    end
  end

  // Only the enable bit is writable; the rest of the word reads as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SLLD_CTRL_RST;
    end else if (clk_en && apb_write) begin
      ctrl_r <= {31'h0000_0000, pwdata[`SLLD_CTRL_EN_BIT]};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_r;
  assign prdata  = sel_mem_r ? {8'h00, mem_rdata} : misc_r;

endmodule : slld_top

// file: bench/slld_host_model.sv
/*
  Host controller model: drives serial clock, data and commit strobe.
  Assumes a caller in the bench invokes send; timing is unrelated to pclk.
*/
`timescale 1ns/10ps

module slld_host_model (
  output logic sclk,
  output logic sdata,
  output logic word_commit_strobe
);
  // =====================================================================
  // Idle levels: clock stands low outside frames.
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    word_commit_strobe = 1'b0;
  end

  // =====================================================================
  // One word, MSB first, 800 ns period; odd offset keeps edges off pclk.
  task send(input logic [23:0] w, input logic commit);
    #37;
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
    sdata = ~sdata; // Released line shows no stale value.
    if (commit) begin
      #800 word_commit_strobe = 1'b1;
      #800 word_commit_strobe = 1'b0;
    end
    #800;
  endtask : send
endmodule : slld_host_model

// file: bench/slld_chk.sv
/*
  Checker of the LO direction outputs of slld_top.
  Assumes it is bound to slld_top and sees only its ports.
*/
`timescale 1ns/10ps

module slld_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lo_direction_pin,
  input wire logic word_commit_strobe,
  input wire logic lo_source,
  input wire logic lo_port_positive_o,
  input wire logic lo_port_positive_oe_n,
  input wire logic lo_port_negative_o,
  input wire logic lo_port_negative_oe_n,
  input wire logic lo_ext_positive_r,
  input wire logic lo_is_output
);
  // =====================================================================
  // Properties.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pin_out;
    lo_direction_pin [*8] |-> ##[0:4] lo_is_output;
  endproperty
  property p_oe;
    lo_port_positive_oe_n == !lo_is_output && lo_port_negative_oe_n == !lo_is_output;
  endproperty
  property p_pos;
    lo_is_output && $past(lo_is_output) |-> lo_port_positive_o == $past(lo_source);
  endproperty
  property p_neg;
    lo_is_output && $past(lo_is_output) |-> lo_port_negative_o == !$past(lo_source);
  endproperty
  property p_ext;
    lo_is_output && $past(lo_is_output) |-> !lo_ext_positive_r;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("LO pins not outputs with pin high");
  a_oe: assert property (p_oe) else $error("LO enables disagree with mode");
  a_pos: assert property (p_pos) else $error("LO positive drive wrong");
  a_neg: assert property (p_neg) else $error("LO negative drive wrong");
  a_ext: assert property (p_ext) else $error("LO capture active in output mode");
  c_out: cover property ($rose(lo_is_output));
  c_in: cover property ($fell(lo_is_output));
  c_commit: cover property ($rose(word_commit_strobe));
endmodule : slld_chk

bind slld_top slld_chk i_slld_chk (.pclk(pclk), .presetn(presetn), .lo_direction_pin(lo_direction_pin),
  .word_commit_strobe(word_commit_strobe), .lo_source(lo_source), .lo_port_positive_o(lo_port_positive_o),
  .lo_port_positive_oe_n(lo_port_positive_oe_n), .lo_port_negative_o(lo_port_negative_o),
  .lo_port_negative_oe_n(lo_port_negative_oe_n), .lo_ext_positive_r(lo_ext_positive_r),
  .lo_is_output(lo_is_output));

// file: bench/slld_tb_top.sv
/*
  Testbench of slld_top: APB tasks plus serial words from the host model.
  Assumes slld_pkg and slld_cfg.svh are compiled ahead.
*/
`timescale 1ns/10ps
`include "slld_cfg.svh"

module slld_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, sclk, sdata, stb, dpin = 1'b0, lo_src = 1'b0, ext_lvl = 1'b0;
  logic po, poe_n, no, noe_n;
  logic xp, xn, cen = 1'b1;
  logic [23:0] w;
  int failures = 0, samples_checked = 0;
  wire pi = poe_n ? ext_lvl : po;
  wire ni = noe_n ? !ext_lvl : no;

  // =====================================================================
  // Clock, free-running LO source and external level.
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    lo_src <= ~lo_src;
    ext_lvl <= ~ext_lvl;
  end

  slld_host_model i_slld_host_model (.sclk(sclk), .sdata(sdata), .word_commit_strobe(stb));
  slld_top i_slld_top (.pclk(pclk), .presetn(presetn), .clk_en(cen), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .sdata(sdata), .word_commit_strobe(stb), .lo_direction_pin(dpin), .lo_source(lo_src),
    .lo_port_positive_i(pi), .lo_port_positive_o(po), .lo_port_positive_oe_n(poe_n),
    .lo_port_negative_i(ni), .lo_port_negative_o(no), .lo_port_negative_oe_n(noe_n),
    .lo_ext_positive_r(xp), .lo_ext_negative_r(xn), .lo_is_output());

  // =====================================================================
  // Verdict and comparison.
  task end_sim;
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    // A timeout ends the run here, so nothing may follow it in this branch.
    if (i == 20) begin
      failures++;
      end_sim();
    end else begin
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask : rd

  // =====================================================================
  // Main sequence.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(`SLLD_OFF_CTRL, `SLLD_CTRL_RST, 32'hffff_ffff);
    rd(12'h100, 32'h0, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `SLLD_OFF_STATUS, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    w = {8'ha5, 8'h3a, 2'b10, 3'b000, 3'h6};
    i_slld_host_model.send(w, 1'b0);
    rd(`SLLD_OFF_SHIFT, {8'h0, w}, 32'hffff_ffff);
    rd(`SLLD_OFF_WORD0 + 12'h018, 32'h0, 32'hffff_ffff);
    for (int n = 0; n < 8; n++) begin
      w = {8'ha5, 8'h3c ^ 8'(n), 2'b10, 3'b000, 3'(n)};
      i_slld_host_model.send(w, 1'b1);
      rd(`SLLD_OFF_WORD0 + 12'(4 * n), {8'h0, w}, 32'hffff_ffff);
    end
    rd(`SLLD_OFF_STATUS, 32'h0000_0800, 32'h0000_ff00);
    i_slld_host_model.send({18'h0, 6'b101_101}, 1'b1);
    rd(`SLLD_OFF_STATUS, 32'h1, 32'h3);
    i_slld_host_model.send({18'h0, 6'b010_101}, 1'b1);
    rd(`SLLD_OFF_STATUS, 32'h2, 32'h3);
    // Input mode: pins released, captures follow the pin levels one cycle late.
    @(negedge pclk);
    chk({28'h0, poe_n, noe_n, xp, xn}, {28'h0, 2'b11, !ext_lvl, ext_lvl});
    @(posedge pclk);
    dpin <= 1'b1;
    repeat (12) @(posedge pclk);
    rd(`SLLD_OFF_STATUS, 32'h5, 32'h7);
    // Output mode: pins driven with the source one cycle late, captures idle.
    @(negedge pclk);
    chk({26'h0, po, no, poe_n, noe_n, xp, xn}, {26'h0, !lo_src, lo_src, 4'h0});
    @(posedge pclk);
    dpin <= 1'b0;
    repeat (12) @(posedge pclk);
    // Port disabled: serial edges are ignored, nothing shifts or commits.
    apb(1'b1, `SLLD_OFF_CTRL, 32'h0);
    rd(`SLLD_OFF_CTRL, 32'h0, 32'hffff_ffff);
    i_slld_host_model.send(24'h5a5a5e, 1'b1);
    rd(`SLLD_OFF_SHIFT, 32'h0000_0015, 32'hffff_ffff);
    rd(`SLLD_OFF_STATUS, 32'h0000_0a00, 32'h0000_ff00);
    // Clock enable low freezes the port even while software has it enabled.
    apb(1'b1, `SLLD_OFF_CTRL, 32'h1);
    cen <= 1'b0;
    i_slld_host_model.send(24'h123456, 1'b1);
    @(posedge pclk);
    cen <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(`SLLD_OFF_SHIFT, 32'h0000_0015, 32'hffff_ffff);
    rd(`SLLD_OFF_STATUS, 32'h0000_0a00, 32'h0000_ff00);
    end_sim();
  end
endmodule : slld_tb_top
